// *** src/pss_pkg.sv ***
// Constants shared by the scan sequencer.
// Assumes a 20 MHz system clock and a
// classic Wishbone register bus.
package pss_pkg;

    // Clock and watchdog timing
    localparam int CLK_HZ = 20_000_000;
    localparam int WD_TICK_MS = 1;
    localparam int CYC_PER_MS =
        CLK_HZ / 1000 * WD_TICK_MS;
    localparam logic [15:0] WD_DEF_MS = 16'h00c8;

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_IMG = 8'h08;
    localparam logic [7:0] A_FORCE = 8'h0c;
    localparam logic [7:0] A_OVR = 8'h10;
    localparam logic [7:0] A_WDOG = 8'h14;
    localparam logic [7:0] A_SCUR = 8'h18;
    localparam logic [7:0] A_SMIN = 8'h1c;
    localparam logic [7:0] A_SMAX = 8'h20;
    localparam logic [7:0] A_SPEC = 8'h24;
    localparam logic [7:0] A_LIVE = 8'h28;
    localparam logic [7:0] A_PROG = 8'h40;
    localparam logic [7:0] A_PEND = 8'h80;

    // Control register fields
    localparam int C_RUN = 0;
    localparam int C_HOLD = 1;
    localparam logic [31:0] CTRL_RST = 32'h0;

    // Force register fields
    localparam int F_VAL = 8;

    // Image bit map
    localparam int Y_LO = 8;
    localparam int Y_HI = 15;
    localparam int NPTS = 8;
    localparam int NPROG = 16;

    // Error codes
    localparam logic [15:0] E_WDOG = 16'h0003;
    localparam logic [15:0] E_PROG = 16'h0004;
    localparam logic [15:0] E_WRITE = 16'h0005;

    // Instruction opcodes, bits 7:5
    localparam logic [2:0] OP_STR = 3'h0;
    localparam logic [2:0] OP_STRI = 3'h1;
    localparam logic [2:0] OP_AND = 3'h2;
    localparam logic [2:0] OP_OR = 3'h3;
    localparam logic [2:0] OP_ANDN = 3'h4;
    localparam logic [2:0] OP_OUT = 3'h5;
    localparam logic [2:0] OP_OUTI = 3'h6;
    localparam logic [2:0] OP_END = 3'h7;

    // Scan segments
    typedef enum logic [2:0] {
        S_IN, S_PER, S_SPC, S_SOLVE, S_OUT, S_DIAG
    } pss_seg_e;

endpackage

// *** src/pss_scan_seq.sv ***
// Scan sequencer of a small controller CPU.
// Assumes synchronised clock domain, field
// inputs from pins, Wishbone master for SW.
`timescale 1ns/10ps
`default_nettype none

module pss_scan_seq #(
    parameter int MS_CYCLES = pss_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] in_pin_i,
    output logic [7:0] out_pin_o,
    output logic run_o
);

    // Input pin synchroniser
    logic [7:0] in_s1;
    logic [7:0] in_s2;

    // Images and control state
    logic [31:0] img;
    logic [31:0] ovr;
    logic [7:0] prog [0:pss_pkg::NPROG-1];
    logic [31:0] ctrl;
    pss_pkg::pss_seg_e seg;
    logic [3:0] pc;
    logic acc;
    logic imm_wait;

    // Force request
    logic frc_pend;
    logic [4:0] frc_adr;
    logic frc_val;

    // Errors
    logic fatal;
    logic nonfatal;
    logic [15:0] err_code;

    // Watchdog and scan timing
    logic [15:0] wd_lim;
    logic [15:0] wd_el;
    logic [15:0] ms_div;
    logic [31:0] scan_cnt;
    logic [31:0] scur;
    logic [31:0] smin;
    logic [31:0] smax;
    logic [15:0] scans;
    logic first_scan;
    logic was_run;

    // Bus decode
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire wr = bus_req & we_i & sel_i[0];
    wire rd_ok = bus_req & ~we_i;
    wire hit_ctrl = adr_i == pss_pkg::A_CTRL;
    wire hit_force = adr_i == pss_pkg::A_FORCE;
    wire hit_ovr = adr_i == pss_pkg::A_OVR;
    wire hit_wdog = adr_i == pss_pkg::A_WDOG;
    wire hit_prog = adr_i >= pss_pkg::A_PROG && adr_i < pss_pkg::A_PEND;
    wire [3:0] prog_idx = adr_i[5:2];

    // Mode decode
    wire run = ctrl[pss_pkg::C_RUN];
    wire hold = ctrl[pss_pkg::C_HOLD];
    wire edit_ok = ~run | hold;
    wire prog_wr = wr & hit_prog & edit_ok;
    wire prog_bad_wr = wr & hit_prog & ~edit_ok;

    // Current instruction decode
    wire [7:0] ins = prog[pc];
    wire [2:0] op = ins[7:5];
    wire [4:0] ba = ins[4:0];
    wire ibit = img[ba];
    wire is_y = ba >= 5'(pss_pkg::Y_LO) &&
        ba <= 5'(pss_pkg::Y_HI);
    wire is_out = op == pss_pkg::OP_OUT ||
        op == pss_pkg::OP_OUTI;
    wire bad_ins = (op == pss_pkg::OP_OUT &&
        ba < 5'(pss_pkg::Y_LO)) ||
        (op == pss_pkg::OP_OUTI && ~is_y) ||
        (op == pss_pkg::OP_STRI && ba >= 5'(pss_pkg::NPTS));
    wire in_solve = seg == pss_pkg::S_SOLVE;
    wire solving = in_solve & run & ~hold;
    wire step = solving & ~imm_wait;
    wire stri_go = step & op == pss_pkg::OP_STRI;
    wire prog_err = step & bad_ins;
    wire wd_trip = solving & wd_el >= wd_lim;
    wire last_ins = op == pss_pkg::OP_END ||
        pc == 4'(pss_pkg::NPROG - 1);
    wire solve_done = ~solving | (step & last_ins);
    wire ms_tick = ms_div == 16'(MS_CYCLES - 1);
    wire go_fatal = prog_err | wd_trip;

    // Live pin index for immediate input
    wire live_bit = in_s2[ba[2:0]];

    // Accumulator next value
    wire next_acc =
        op == pss_pkg::OP_STR ? ibit :
        op == pss_pkg::OP_STRI ? live_bit :
        op == pss_pkg::OP_AND ? acc & ibit :
        op == pss_pkg::OP_OR ? acc | ibit :
        op == pss_pkg::OP_ANDN ? acc & ~ibit :
        acc;

    // Special relay word
    wire [31:0] spec = {13'h0, nonfatal, fatal,
        first_scan, scans};

    // Status word
    wire [31:0] stat = {err_code, 12'h0, hold,
        nonfatal, fatal, run};

    // Read data select
    wire [31:0] rdata =
        hit_ctrl ? ctrl :
        adr_i == pss_pkg::A_STAT ? stat :
        adr_i == pss_pkg::A_IMG ? img :
        hit_ovr ? ovr :
        hit_wdog ? {16'h0, wd_lim} :
        adr_i == pss_pkg::A_SCUR ? scur :
        adr_i == pss_pkg::A_SMIN ? smin :
        adr_i == pss_pkg::A_SMAX ? smax :
        adr_i == pss_pkg::A_SPEC ? spec :
        adr_i == pss_pkg::A_LIVE ? {24'h0, in_s2} :
        hit_prog ? {24'h0, prog[prog_idx]} :
        32'h0;

    // Two-flop pin synchroniser
    always_ff @(posedge clk_i) begin
        in_s1 <= in_pin_i;
        in_s2 <= in_s1;
    end

    // Bus answer, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= rd_ok ? rdata : 32'h0;
        end
    end

    // Control register and mode drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= pss_pkg::CTRL_RST;
        end else if (go_fatal) begin
            ctrl <= 32'h0;
        end else if (wr & hit_ctrl) begin
            ctrl <= {30'h0, dat_i[1:0]};
        end
    end

    // Program memory, edits only when allowed
    always_ff @(posedge clk_i) begin
        if (prog_wr) begin
            prog[prog_idx] <= dat_i[7:0];
        end
    end

    // Override mask and watchdog limit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovr <= 32'h0;
            wd_lim <= pss_pkg::WD_DEF_MS;
        end else begin
            if (wr & hit_ovr) begin
                ovr <= dat_i;
            end
            if (wr & hit_wdog) begin
                wd_lim <= dat_i[15:0];
            end
        end
    end

    // Pending force; set wins over the consume
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frc_pend <= 1'b0;
            frc_adr <= 5'h0;
            frc_val <= 1'b0;
        end else if (wr & hit_force) begin
            frc_pend <= 1'b1;
            frc_adr <= dat_i[4:0];
            frc_val <= dat_i[pss_pkg::F_VAL];
        end else if (seg == pss_pkg::S_PER) begin
            frc_pend <= 1'b0;
        end
    end

    // Segment sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg <= pss_pkg::S_IN;
        end else begin
            case (seg)
                pss_pkg::S_IN: seg <= pss_pkg::S_PER;
                pss_pkg::S_PER: seg <= pss_pkg::S_SPC;
                pss_pkg::S_SPC: seg <= pss_pkg::S_SOLVE;
                pss_pkg::S_SOLVE: begin
                    if (go_fatal | solve_done) begin
                        seg <= pss_pkg::S_OUT;
                    end
                end
                pss_pkg::S_OUT: seg <= pss_pkg::S_DIAG;
                default: seg <= pss_pkg::S_IN;
            endcase
        end
    end

    // Program counter, accumulator, input stall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= 4'h0;
            acc <= 1'b0;
            imm_wait <= 1'b0;
        end else if (~in_solve) begin
            pc <= 4'h0;
            imm_wait <= 1'b0;
        end else if (step) begin
            acc <= next_acc;
            pc <= pc + 4'h1;
            imm_wait <= stri_go;
        end else begin
            imm_wait <= 1'b0;
        end
    end

    // Image register updates
    generate
        for (genvar i = 0; i < 32; i++) begin : g_img
            wire own = ~ovr[i];
            wire frc_hit = frc_pend & frc_adr == 5'(i);
            wire sol_hit = step & is_out & ~bad_ins &
                ba == 5'(i);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    img[i] <= 1'b0;
                end else if (seg == pss_pkg::S_PER &&
                        frc_hit) begin
                    img[i] <= frc_val;
                end else if (own && sol_hit) begin
                    img[i] <= acc;
                end else if (i < pss_pkg::NPTS && own &&
                        seg == pss_pkg::S_IN) begin
                    img[i] <= in_s2[i % 8];
                end
            end
        end
    endgenerate

    // Physical outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_pin_o <= 8'h0;
        end else if (go_fatal | ~run) begin
            out_pin_o <= 8'h0;
        end else if (hold) begin
            out_pin_o <= out_pin_o;
        end else if (step && op == pss_pkg::OP_OUTI &&
                is_y && ~ovr[ba]) begin
            out_pin_o[ba[2:0]] <= acc;
        end else if (seg == pss_pkg::S_OUT) begin
            out_pin_o <= img[pss_pkg::Y_HI:pss_pkg::Y_LO];
        end
    end

    // Run indicator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o <= 1'b0;
        end else begin
            run_o <= run & ~go_fatal;
        end
    end

    // Error flags; detection wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fatal <= 1'b0;
            nonfatal <= 1'b0;
            err_code <= 16'h0;
        end else if (wd_trip) begin
            fatal <= 1'b1;
            err_code <= pss_pkg::E_WDOG;
        end else if (prog_err) begin
            fatal <= 1'b1;
            err_code <= pss_pkg::E_PROG;
        end else if (prog_bad_wr) begin
            nonfatal <= 1'b1;
            err_code <= pss_pkg::E_WRITE;
        end else if (wr && adr_i == pss_pkg::A_STAT) begin
            fatal <= 1'b0;
            nonfatal <= 1'b0;
            err_code <= 16'h0;
        end
    end

    // Watchdog millisecond counter
    always_ff @(posedge clk_i) begin
        if (rst_i || seg == pss_pkg::S_DIAG) begin
            ms_div <= 16'h0;
            wd_el <= 16'h0;
        end else if (solving) begin
            if (ms_tick) begin
                ms_div <= 16'h0;
                wd_el <= wd_el + 16'h1;
            end else begin
                ms_div <= ms_div + 16'h1;
            end
        end
    end

    // Scan length counter
    always_ff @(posedge clk_i) begin
        if (rst_i || seg == pss_pkg::S_DIAG) begin
            scan_cnt <= 32'h1;
        end else begin
            scan_cnt <= scan_cnt + 32'h1;
        end
    end

    // Scan time statistics, min and max reset on entering run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scur <= 32'h0;
            smin <= 32'hffffffff;
            smax <= 32'h0;
            was_run <= 1'b0;
        end else begin
            was_run <= run;
            if (run & ~was_run) begin
                smin <= 32'hffffffff;
                smax <= 32'h0;
            end else if (seg == pss_pkg::S_DIAG) begin
                scur <= scan_cnt;
                if (run && scan_cnt < smin) begin
                    smin <= scan_cnt;
                end
                if (run && scan_cnt > smax) begin
                    smax <= scan_cnt;
                end
            end
        end
    end

    // Special relay refresh
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scans <= 16'h0;
            first_scan <= 1'b0;
        end else if (seg == pss_pkg::S_SPC) begin
            scans <= scans + 16'h1;
            first_scan <= run & ~|scans;
        end else if (run & ~was_run) begin
            scans <= 16'h0;
        end
    end

endmodule

`default_nettype wire

// *** src/pss_fix_note.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** tb/pss_scan_seq_properties.sv ***
// Port checker for the scan sequencer.
// Assumes it is bound to the top module; one clock.
`timescale 1ns/10ps
`default_nettype none

module pss_scan_seq_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [7:0] in_pin_i,
    input wire logic [7:0] out_pin_o,
    input wire logic run_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Taken bus request and control writes
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ctrl(logic v);
        s_req ##0 (we_i && sel_i[0] && adr_i == pss_pkg::A_CTRL && dat_i[pss_pkg::C_RUN] == v);
    endsequence

    chk_ack_answer: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_unmapped_zero: assert property (s_req ##0 (!we_i && adr_i == 8'h30) |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_run_start: assert property (s_ctrl(1'b1) |-> ##[1:2] run_o)
        else $error("run not entered");
    chk_run_stop: assert property (s_ctrl(1'b0) |-> ##[1:2] !run_o)
        else $error("run not left");
    chk_prog_outs_off: assert property (!run_o && !$past(run_o) && !$past(run_o, 2) |-> out_pin_o == 8'h0)
        else $error("outputs on in program mode");
    chk_out_only_run: assert property (!$stable(out_pin_o) |-> run_o || $past(run_o))
        else $error("outputs moved outside run");
    chk_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && !run_o && out_pin_o == 8'h0)
        else $error("outputs active after reset");
endmodule

`default_nettype wire

// *** tb/pss_field_model.sv ***
// Field input points seen by the sequencer.
// Assumes the bench sets the wanted levels.
`timescale 1ns/10ps
`default_nettype none

module pss_field_model (
    input wire logic clk_i,
    input wire logic [7:0] lvl_i,
    input wire logic [7:0] out_pin_i,
    output logic [7:0] in_pin_o
);
    // Switch contacts settle on a clock edge
    always_ff @(posedge clk_i) begin
        in_pin_o <= lvl_i;
    end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// Bench for the scan sequencer over Wishbone.
// Assumes the field model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h0, lvl = 8'h0, in_pin_i, out_pin_o;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, run_o;
    int n_fail = 0, checks_done = 0;

    pss_scan_seq #(.MS_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .in_pin_i(in_pin_i), .out_pin_o(out_pin_o),
        .run_o(run_o));
    pss_field_model u_fld (.clk_i(clk_i), .lvl_i(lvl), .out_pin_i(out_pin_o),
        .in_pin_o(in_pin_i));

    // Clock, 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One classic cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) begin
                break;
            end
        end
        rd = dat_o;
        if (i == 20) begin
            n_fail++;
            finish_test;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // Bounded wait for an output pattern
    task automatic wait_out(input logic [7:0] e);
        int i;
        for (i = 0; i < 300 && out_pin_o !== e; i++) begin
            @(posedge clk_i);
        end
        `CHK(out_pin_o, e)
        if (i == 300) begin
            finish_test;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(pss_pkg::A_CTRL, pss_pkg::CTRL_RST);
        rd_chk(pss_pkg::A_WDOG, {16'h0, pss_pkg::WD_DEF_MS});
        rd_chk(8'h30, 32'h0);
        wb(1'b1, pss_pkg::A_CTRL, 32'h0);
        lvl <= 8'h03;
        repeat (20) @(posedge clk_i);
        rd_chk(pss_pkg::A_IMG, 32'h3);
        rd_chk(pss_pkg::A_LIVE, 32'h3);
        `CHK(out_pin_o, 8'h0)
        // STR X0, OUT Y0, STRI X1, OUT Y1, END
        wb(1'b1, pss_pkg::A_PROG, 32'h00);
        wb(1'b1, pss_pkg::A_PROG + 8'h04, 32'ha8);
        wb(1'b1, pss_pkg::A_PROG + 8'h08, 32'h21);
        wb(1'b1, pss_pkg::A_PROG + 8'h0c, 32'ha9);
        wb(1'b1, pss_pkg::A_PROG + 8'h10, 32'he0);
        wb(1'b1, pss_pkg::A_WDOG, 32'h5);
        rd_chk(pss_pkg::A_WDOG, 32'h5);
        wb(1'b1, pss_pkg::A_CTRL, 32'h1);
        wait_out(8'h03);
        lvl <= 8'h02;
        wait_out(8'h02);
        lvl <= 8'h03;
        wait_out(8'h03);
        rd_chk(pss_pkg::A_SCUR, 32'h0000000b);
        rd_chk(pss_pkg::A_SMAX, 32'h0000000b);
        // Override Y0, then field change
        wb(1'b1, pss_pkg::A_OVR, 32'h100);
        lvl <= 8'h02;
        repeat (60) @(posedge clk_i);
        `CHK(out_pin_o, 8'h03)
        wb(1'b1, pss_pkg::A_FORCE, 32'h8);
        wait_out(8'h02);
        lvl <= 8'h03;
        repeat (60) @(posedge clk_i);
        `CHK(out_pin_o, 8'h02)
        wb(1'b1, pss_pkg::A_OVR, 32'h0);
        wait_out(8'h03);
        wb(1'b1, pss_pkg::A_FORCE, 32'h8);
        repeat (60) @(posedge clk_i);
        `CHK(out_pin_o, 8'h03)
        // Run edit hold, then bad program
        wb(1'b1, pss_pkg::A_CTRL, 32'h3);
        lvl <= 8'h00;
        repeat (60) @(posedge clk_i);
        `CHK(out_pin_o, 8'h03)
        wb(1'b1, pss_pkg::A_PROG + 8'h10, 32'ha0);
        wb(1'b1, pss_pkg::A_CTRL, 32'h1);
        lvl <= 8'h03;
        wait_out(8'h00);
        `CHK(run_o, 1'b0)
        rd_chk(pss_pkg::A_STAT, {pss_pkg::E_PROG, 16'h2});
        // Watchdog trip with zero limit
        wb(1'b1, pss_pkg::A_STAT, 32'h0);
        wb(1'b1, pss_pkg::A_PROG + 8'h10, 32'he0);
        wb(1'b1, pss_pkg::A_CTRL, 32'h1);
        wb(1'b1, pss_pkg::A_WDOG, 32'h0);
        repeat (40) @(posedge clk_i);
        `CHK(run_o, 1'b0)
        rd_chk(pss_pkg::A_STAT, {pss_pkg::E_WDOG, 16'h2});
        // Nonfatal error keeps run mode
        wb(1'b1, pss_pkg::A_STAT, 32'h0);
        wb(1'b1, pss_pkg::A_WDOG, 32'hc8);
        wb(1'b1, pss_pkg::A_CTRL, 32'h1);
        wait_out(8'h03);
        wb(1'b1, pss_pkg::A_PROG + 8'h14, 32'he0);
        rd_chk(pss_pkg::A_STAT, {pss_pkg::E_WRITE, 16'h5});
        wb(1'b1, pss_pkg::A_CTRL, 32'h0);
        wait_out(8'h00);
        finish_test;
    end

    // Overall run limit
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        finish_test;
    end
endmodule

bind pss_scan_seq pss_scan_seq_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .in_pin_i(in_pin_i),
    .out_pin_o(out_pin_o), .run_o(run_o));

`default_nettype wire
